// ---- hw/rtcap_timer.sv ----
// reload timer with capture: apb registers, clock selection, counters and flags
//
// Summary of operation
// - split bit selects two 8-bit or one 16-bit
// - 16-bit wrap loads both reload bytes
// - 16-bit overflow sets high overflow flag
// - 16-bit overflow requests interrupt when enabled
// - low byte wrap interrupts when low enable set
// - split bytes reload from their own registers
// - split: run gates high byte only
// - byte clock: system, divide 12, external/8
// - external divided clock synchronised before use
// - split: each byte wrap sets its flag
// - split: high wrap interrupts, low optionally
// - flags cleared only by software writes
// - capture copies counter, sets high flag
// - capture every eight slow clock cycles
`default_nettype none
`include "rtcap_cfg.svh"
module rtcap_timer (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // slow clock inputs
   input  wire logic        ext_osc_clk,
   input  wire logic        rtc_clk,
   // interrupt request level
   output logic             timer_irq
);
   rtcap_pkg::rtcap_byte_t  timer_control_reg;
   rtcap_pkg::rtcap_byte_t  clock_div_ctrl_reg;
   rtcap_pkg::rtcap_byte_t  irq_enable_reg;
   rtcap_pkg::rtcap_byte_t  reload_low_reg;
   rtcap_pkg::rtcap_byte_t  reload_high_reg;
   rtcap_pkg::rtcap_byte_t  count_low_reg;
   rtcap_pkg::rtcap_byte_t  count_high_reg;
   rtcap_pkg::rtcap_byte_t  rdata_next;
   rtcap_pkg::rtcap_mode_t  mode;
   logic [3:0]              sys_div_reg;
   logic                    sys12_tick_reg;
   logic                    tick_low;
   logic                    tick_high;
   logic                    inc_low;
   logic                    inc_high;
   logic                    wrap_low;
   logic                    wrap_high;
   logic                    wrap_wide;
   logic                    capture_tick;
   logic                    capture_ev;
   logic                    set_high_flag;
   logic                    set_low_flag;
   logic [9:0]              reg_idx;
   logic                    mapped;
   logic                    wr_en;
   logic                    rd_setup;
   logic                    wr_timer_control;
   logic                    wr_clock_div_ctrl;
   logic                    wr_irq_enable;
   logic                    wr_reload_low;
   logic                    wr_reload_high;
   logic                    wr_count_low;
   logic                    wr_count_high;
   rtcap_tick_if            ext_tick ();
   rtcap_tick_if            rtc_tick ();

   // ************************************************************************
   // apb decode
   // ************************************************************************
   // the slave never waits: read data is captured in the setup cycle
   assign reg_idx  = paddr[11:2];
   assign mapped   = (paddr[1:0] == 2'b00) &&
                     (reg_idx == `RTCAP_IDX_IRQ_ENABLE    ||
                      reg_idx == `RTCAP_IDX_CLOCK_DIV_CTRL ||
                      reg_idx == `RTCAP_IDX_TIMER_CONTROL ||
                      reg_idx == `RTCAP_IDX_RELOAD_LOW    ||
                      reg_idx == `RTCAP_IDX_RELOAD_HIGH   ||
                      reg_idx == `RTCAP_IDX_COUNT_LOW     ||
                      reg_idx == `RTCAP_IDX_COUNT_HIGH);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign wr_en    = psel && penable && pwrite && mapped && pstrb[0];
   assign rd_setup = psel && !penable && !pwrite;

   always_comb begin
      rdata_next = `RTCAP_RESET_BYTE;
      case (reg_idx)
         `RTCAP_IDX_IRQ_ENABLE:     rdata_next = irq_enable_reg;
         `RTCAP_IDX_CLOCK_DIV_CTRL: rdata_next = clock_div_ctrl_reg;
         `RTCAP_IDX_TIMER_CONTROL:  rdata_next = timer_control_reg;
         `RTCAP_IDX_RELOAD_LOW:     rdata_next = reload_low_reg;
         `RTCAP_IDX_RELOAD_HIGH:    rdata_next = reload_high_reg;
         `RTCAP_IDX_COUNT_LOW:      rdata_next = count_low_reg;
         `RTCAP_IDX_COUNT_HIGH:     rdata_next = count_high_reg;
         default:                   rdata_next = `RTCAP_RESET_BYTE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= {24'h00_0000, (paddr[1:0] == 2'b00) ? rdata_next : `RTCAP_RESET_BYTE};
      end
   end

   // ************************************************************************
   // write strobes
   // ************************************************************************
   assign wr_timer_control  = wr_en && (reg_idx == `RTCAP_IDX_TIMER_CONTROL);
   assign wr_clock_div_ctrl = wr_en && (reg_idx == `RTCAP_IDX_CLOCK_DIV_CTRL);
   assign wr_irq_enable     = wr_en && (reg_idx == `RTCAP_IDX_IRQ_ENABLE);
   assign wr_reload_low     = wr_en && (reg_idx == `RTCAP_IDX_RELOAD_LOW);
   assign wr_reload_high    = wr_en && (reg_idx == `RTCAP_IDX_RELOAD_HIGH);
   assign wr_count_low      = wr_en && (reg_idx == `RTCAP_IDX_COUNT_LOW);
   assign wr_count_high     = wr_en && (reg_idx == `RTCAP_IDX_COUNT_HIGH);

   // ************************************************************************
   // clock sources
   // ************************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_div_reg <= 4'h0;
      end else begin
         sys_div_reg <= (sys_div_reg == `RTCAP_SYS_DIV - 4'd1) ? 4'h0 : sys_div_reg + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys12_tick_reg <= 1'b0;
      end else begin
         sys12_tick_reg <= (sys_div_reg == `RTCAP_SYS_DIV - 4'd1);
      end
   end

   rtcap_slow_tick u_ext_tick (
      .pclk     (pclk),
      .presetn  (presetn),
      .slow_clk (ext_osc_clk),
      .out      (ext_tick)
   );

   rtcap_slow_tick u_rtc_tick (
      .pclk     (pclk),
      .presetn  (presetn),
      .slow_clk (rtc_clk),
      .out      (rtc_tick)
   );

   // selected divided source, or every pclk when the byte's select bit is set
   assign tick_low  = clock_div_ctrl_reg[`RTCAP_CDC_LOW_CLK_SEL] ? 1'b1 :
                      (timer_control_reg[`RTCAP_TC_EXT_CLK_SEL] ? ext_tick.tick
                                                                : sys12_tick_reg);
   assign tick_high = clock_div_ctrl_reg[`RTCAP_CDC_HIGH_CLK_SEL] ? 1'b1 :
                      (timer_control_reg[`RTCAP_TC_EXT_CLK_SEL] ? ext_tick.tick
                                                                : sys12_tick_reg);

   // ************************************************************************
   // mode and counting
   // ************************************************************************
   // capture in split mode is left to software to avoid; it still captures
   always_comb begin
      if (timer_control_reg[`RTCAP_TC_SPLIT]) begin
         mode = rtcap_pkg::RTCAP_MODE_SPLIT;
      end else if (timer_control_reg[`RTCAP_TC_CAPTURE_EN]) begin
         mode = rtcap_pkg::RTCAP_MODE_CAPTURE;
      end else begin
         mode = rtcap_pkg::RTCAP_MODE_WIDE;
      end
   end

   always_comb begin
      inc_low  = 1'b0;
      inc_high = 1'b0;
      unique case (mode)
         rtcap_pkg::RTCAP_MODE_SPLIT: begin
            inc_low  = tick_low;
            inc_high = tick_high && timer_control_reg[`RTCAP_TC_RUN];
         end
         rtcap_pkg::RTCAP_MODE_WIDE,
         rtcap_pkg::RTCAP_MODE_CAPTURE: begin
            inc_low  = tick_low && timer_control_reg[`RTCAP_TC_RUN];
            inc_high = inc_low && (count_low_reg == 8'hff);
         end
      endcase
   end

   assign wrap_low  = inc_low && (count_low_reg == 8'hff);
   assign wrap_high = inc_high && (count_high_reg == 8'hff);
   assign wrap_wide = (mode != rtcap_pkg::RTCAP_MODE_SPLIT) && wrap_high;

   // a software write to a count byte wins over counting in that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_low_reg <= `RTCAP_RESET_BYTE;
      end else if (wr_count_low) begin
         count_low_reg <= pwdata[7:0];
      end else if (wrap_wide) begin
         count_low_reg <= reload_low_reg;
      end else if (wrap_low && mode == rtcap_pkg::RTCAP_MODE_SPLIT) begin
         count_low_reg <= reload_low_reg;
      end else if (inc_low) begin
         count_low_reg <= count_low_reg + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_high_reg <= `RTCAP_RESET_BYTE;
      end else if (wr_count_high) begin
         count_high_reg <= pwdata[7:0];
      end else if (wrap_high) begin
         count_high_reg <= reload_high_reg;
      end else if (inc_high) begin
         count_high_reg <= count_high_reg + 8'h01;
      end
   end

   // ************************************************************************
   // capture and reload registers
   // ************************************************************************
   assign capture_tick = timer_control_reg[`RTCAP_TC_CAP_CLK_SEL] ? ext_tick.tick
                                                                 : rtc_tick.tick;
   assign capture_ev   = timer_control_reg[`RTCAP_TC_CAPTURE_EN] && capture_tick;

   // a capture wins over a software write to the reload bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_low_reg <= `RTCAP_RESET_BYTE;
      end else if (capture_ev) begin
         reload_low_reg <= count_low_reg;
      end else if (wr_reload_low) begin
         reload_low_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_high_reg <= `RTCAP_RESET_BYTE;
      end else if (capture_ev) begin
         reload_high_reg <= count_high_reg;
      end else if (wr_reload_high) begin
         reload_high_reg <= pwdata[7:0];
      end
   end

   // ************************************************************************
   // control and flags
   // ************************************************************************
   assign set_high_flag = wrap_high || capture_ev;
   assign set_low_flag  = wrap_low;

   // hardware only ever sets the flags; a set in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_reg <= `RTCAP_RESET_BYTE;
      end else begin
         if (wr_timer_control) begin
            timer_control_reg <= pwdata[7:0];
         end
         if (set_high_flag) begin
            timer_control_reg[`RTCAP_TC_HIGH_OVF] <= 1'b1;
         end
         if (set_low_flag) begin
            timer_control_reg[`RTCAP_TC_LOW_OVF] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_div_ctrl_reg <= `RTCAP_RESET_BYTE;
      end else if (wr_clock_div_ctrl) begin
         clock_div_ctrl_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_reg <= `RTCAP_RESET_BYTE;
      end else if (wr_irq_enable) begin
         irq_enable_reg <= pwdata[7:0];
      end
   end

   // ************************************************************************
   // interrupt request
   // ************************************************************************
   // level request that stays up until software clears the flags or their enable bits
   assign timer_irq = irq_enable_reg[`RTCAP_IE_TIMER] &&
                      (timer_control_reg[`RTCAP_TC_HIGH_OVF] ||
                       (timer_control_reg[`RTCAP_TC_LOW_IRQ_EN] &&
                        timer_control_reg[`RTCAP_TC_LOW_OVF]));
endmodule : rtcap_timer
`default_nettype wire

// ---- shared/rtcap_cfg.svh ----
// register indices, field positions, reset values and timing counts of the reload timer
`ifndef RTCAP_CFG_SVH
`define RTCAP_CFG_SVH

// ***************************************************************************
// register indices (byte address is four times the index)
// ***************************************************************************
`define RTCAP_IDX_IRQ_ENABLE      10'h0a8
`define RTCAP_IDX_CLOCK_DIV_CTRL  10'h08e
`define RTCAP_IDX_TIMER_CONTROL   10'h0c8
`define RTCAP_IDX_RELOAD_LOW      10'h0ca
`define RTCAP_IDX_RELOAD_HIGH     10'h0cb
`define RTCAP_IDX_COUNT_LOW       10'h0cc
`define RTCAP_IDX_COUNT_HIGH      10'h0cd

// ***************************************************************************
// timer_control fields
// ***************************************************************************
`define RTCAP_TC_HIGH_OVF         7
`define RTCAP_TC_LOW_OVF          6
`define RTCAP_TC_LOW_IRQ_EN       5
`define RTCAP_TC_CAPTURE_EN       4
`define RTCAP_TC_SPLIT            3
`define RTCAP_TC_RUN              2
`define RTCAP_TC_CAP_CLK_SEL      1
`define RTCAP_TC_EXT_CLK_SEL      0

// ***************************************************************************
// other fields and reset values
// ***************************************************************************
`define RTCAP_CDC_HIGH_CLK_SEL    5
`define RTCAP_CDC_LOW_CLK_SEL     4
`define RTCAP_IE_TIMER            5
`define RTCAP_RESET_BYTE          8'h00

// ***************************************************************************
// clock division
// ***************************************************************************
`define RTCAP_SYS_DIV             4'd12
`define RTCAP_SLOW_DIV            3'd7

`endif

// ---- shared/rtcap_pkg.sv ----
// types of the reload timer with capture
`default_nettype none
package rtcap_pkg;
   typedef logic [7:0]  rtcap_byte_t;
   typedef logic [15:0] rtcap_word_t;
   typedef enum logic [2:0] {
      RTCAP_MODE_WIDE    = 3'b001,
      RTCAP_MODE_SPLIT   = 3'b010,
      RTCAP_MODE_CAPTURE = 3'b100
   } rtcap_mode_t;
endpackage : rtcap_pkg
`default_nettype wire

// ---- shared/rtcap_tick_if.sv ----
// one-cycle tick passed from a slow-clock divider to the timer core
`default_nettype none
interface rtcap_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface : rtcap_tick_if
`default_nettype wire

// ---- hw/rtcap_slow_tick.sv ----
// synchroniser, falling-edge detect and divide-by-eight for one slow clock input
`default_nettype none
`include "rtcap_cfg.svh"
module rtcap_slow_tick (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // slow clock seen as a level
   input  wire logic slow_clk,
   // tick towards the core
   rtcap_tick_if.src out
);
   logic       sync1_reg;
   logic       sync2_reg;
   logic       prev_reg;
   logic [2:0] div_reg;
   logic       tick_reg;

   // ************************************************************************
   // synchroniser
   // ************************************************************************
   // the slow clock is unrelated to pclk, so it is sampled twice first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         sync1_reg <= slow_clk;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // ************************************************************************
   // divide by eight
   // ************************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg  <= 3'h0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (prev_reg && !sync2_reg) begin
            div_reg  <= div_reg + 3'h1;
            tick_reg <= (div_reg == `RTCAP_SLOW_DIV);
         end
      end
   end

   assign out.tick = tick_reg;
endmodule : rtcap_slow_tick
`default_nettype wire

// ---- sim/rtcap_timer_monitor.sv ----
// port checker of the reload timer with capture, bound to the top module
`default_nettype none
`include "rtcap_cfg.svh"
module rtcap_timer_monitor (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // slow clocks and interrupt
   input wire logic        ext_osc_clk,
   input wire logic        rtc_clk,
   input wire logic        timer_irq
);
   localparam logic [9:0] ix_ie = `RTCAP_IDX_IRQ_ENABLE;
   localparam logic [9:0] ix_tc = `RTCAP_IDX_TIMER_CONTROL;
   localparam logic [9:0] ix_rl = `RTCAP_IDX_RELOAD_LOW;
   logic [9:0] idx;
   logic       acc, bad, wr, rd, ie_sh, cap_sh, tc_wr, rl_dirty;
   logic [7:0] tc_seen, rl_sh;
   // ***********************************************************************
   // shadows of software writes; conservative so no false alarm is raised
   // ***********************************************************************
   assign idx = paddr[11:2];
   assign acc = psel && penable;
   assign bad = paddr[1:0] != 2'b00 || !(idx inside {ix_ie, ix_tc, ix_rl,
      `RTCAP_IDX_CLOCK_DIV_CTRL, `RTCAP_IDX_RELOAD_HIGH, `RTCAP_IDX_COUNT_LOW,
      `RTCAP_IDX_COUNT_HIGH});
   assign wr  = acc && pwrite && pstrb[0] && !bad;
   assign rd  = acc && !pwrite && !bad;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_sh    <= 1'b0;
         cap_sh   <= 1'b0;
         tc_wr    <= 1'b0;
         rl_dirty <= 1'b0;
         tc_seen  <= 8'h00;
         rl_sh    <= 8'h00;
      end else begin
         if (wr && idx == ix_ie) ie_sh <= pwdata[5];
         if (wr && idx == ix_tc) cap_sh <= pwdata[4];
         if (acc && pwrite && idx == ix_tc) tc_wr <= 1'b1;
         else if (rd && idx == ix_tc) tc_wr <= 1'b0;
         if (rd && idx == ix_tc) tc_seen <= prdata[7:0];
         if (wr && idx == ix_rl) rl_sh <= pwdata[7:0];
         if (cap_sh) rl_dirty <= 1'b1;
         else if (wr && idx == ix_rl) rl_dirty <= 1'b0;
      end
   end
   // ***********************************************************************
   // assertions
   // ***********************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_tc_read;
      rd && idx == ix_tc;
   endsequence
   a_zero_wait: assert property (s_setup ##1 acc |-> pready)
      else $error("apb access not answered at once");
   a_unmapped_refused: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_irq_needs_enable: assert property (!ie_sh |-> !timer_irq)
      else $error("interrupt while disabled");
   a_irq_from_flags: assert property (s_tc_read |-> $past(timer_irq) ==
      ($past(ie_sh) && (prdata[7] || (prdata[5] && prdata[6]))))
      else $error("interrupt level disagrees with flags");
   a_flags_sticky: assert property (s_tc_read ##0 !tc_wr |->
      (prdata[7:6] & tc_seen[7:6]) == tc_seen[7:6])
      else $error("overflow flag cleared by hardware");
   a_irq_no_self_clear: assert property ($fell(timer_irq) |->
      $past(acc && pwrite && (idx == ix_tc || idx == ix_ie)))
      else $error("interrupt dropped without a write");
   a_flag_set_raises: assert property (wr && idx == ix_tc && pwdata[7] && ie_sh |=> timer_irq)
      else $error("high flag did not raise interrupt");
   a_reload_kept: assert property (rd && idx == ix_rl && !rl_dirty |-> prdata[7:0] == rl_sh)
      else $error("reload changed without capture");
endmodule : rtcap_timer_monitor
bind rtcap_timer rtcap_timer_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .ext_osc_clk, .rtc_clk, .timer_irq);
`default_nettype wire

// ---- sim/rtcap_timer_tb.sv ----
// self-checking testbench of the reload timer with capture
`default_nettype none
`include "rtcap_cfg.svh"
module rtcap_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] ix_ie = `RTCAP_IDX_IRQ_ENABLE;
   localparam logic [9:0] ix_ck = `RTCAP_IDX_CLOCK_DIV_CTRL;
   localparam logic [9:0] ix_tc = `RTCAP_IDX_TIMER_CONTROL;
   localparam logic [9:0] ix_rl = `RTCAP_IDX_RELOAD_LOW;
   localparam logic [9:0] ix_rh = `RTCAP_IDX_RELOAD_HIGH;
   localparam logic [9:0] ix_cl = `RTCAP_IDX_COUNT_LOW;
   localparam logic [9:0] ix_ch = `RTCAP_IDX_COUNT_HIGH;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        ext_osc_clk, rtc_clk, timer_irq, re;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [7:0]  rv;
   int          fails, checks, cycles;
   rtcap_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .pready, .pslverr, .prdata, .ext_osc_clk, .rtc_clk, .timer_irq);
   // ***********************************************************************
   // clock, timeout and shared tasks
   // ***********************************************************************
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // the whole run needs about 860 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fails++;
         $display("MISMATCH at %0t: timeout", $time);
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic check_eq(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check_eq
   task automatic check_rng(input logic [7:0] got, lo, hi, input string what);
      checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h", $time, what, got);
      end
   endtask : check_rng
   // called just after a rising edge; holds the request until pready is seen
   task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      check_eq({7'h0, pready}, 8'h01, "apb answer");
      rv = prdata[7:0];
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [9:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d);
   endtask : wr
   task automatic rd(input logic [9:0] ix, input logic [7:0] exp, input string what);
      apb(1'b0, ix, 8'h00);
      check_eq(rv, exp, what);
   endtask : rd
   task automatic irq(input logic [7:0] exp, input string what);
      check_eq({7'h0, timer_irq}, exp, what);
   endtask : irq
   // eight pclk per slow period, so the synchroniser sees every level
   task automatic slow(input logic s, input int n);
      repeat (n) begin
         repeat (4) @(posedge pclk);
         if (s) ext_osc_clk <= 1'b1;
         else rtc_clk <= 1'b1;
         repeat (4) @(posedge pclk);
         if (s) ext_osc_clk <= 1'b0;
         else rtc_clk <= 1'b0;
      end
      repeat (8) @(posedge pclk);
   endtask : slow
   // ***********************************************************************
   // scenarios
   // ***********************************************************************
   task automatic t_reset();
      logic [9:0] regs [7] = '{ix_ie, ix_ck, ix_tc, ix_rl, ix_rh, ix_cl, ix_ch};
      foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
      apb(1'b0, 10'h001, 8'h00);
      check_eq({7'h0, re}, 8'h01, "unmapped refused");
      wr(ix_rl, 8'h5a);
      rd(ix_rl, 8'h5a, "reload read back");
      $display("test reset done");
   endtask : t_reset
   task automatic t_wide();
      logic [7:0] held;
      wr(ix_ck, 8'h10);
      wr(ix_rh, 8'h12);
      wr(ix_rl, 8'h34);
      wr(ix_ch, 8'hff);
      wr(ix_cl, 8'hf0);
      wr(ix_tc, 8'h04);
      repeat (40) @(posedge pclk);
      rd(ix_ch, 8'h12, "wide reload high");
      apb(1'b0, ix_cl, 8'h00);
      check_rng(rv, 8'h35, 8'ha0, "wide reload low");
      rd(ix_tc, 8'hc4, "wide flags");
      irq(8'h00, "irq masked");
      wr(ix_ie, 8'h20);
      irq(8'h01, "irq on overflow");
      rd(ix_tc, 8'hc4, "flags kept");
      wr(ix_tc, 8'h00);
      irq(8'h00, "irq cleared");
      wr(ix_tc, 8'h80);
      irq(8'h01, "irq from written flag");
      wr(ix_tc, 8'h00);
      irq(8'h00, "written flag cleared");
      apb(1'b0, ix_cl, 8'h00);
      held = rv;
      repeat (20) @(posedge pclk);
      rd(ix_cl, held, "stopped count");
      wr(ix_ch, 8'h00);
      wr(ix_cl, 8'hf0);
      wr(ix_tc, 8'h24);
      repeat (30) @(posedge pclk);
      rd(ix_tc, 8'h64, "low wrap flag");
      irq(8'h01, "low wrap irq");
      wr(ix_tc, 8'h44);
      irq(8'h00, "low irq disabled");
      wr(ix_tc, 8'h00);
      $display("test wide done");
   endtask : t_wide
   task automatic t_split();
      wr(ix_ck, 8'h30);
      wr(ix_rl, 8'ha0);
      wr(ix_rh, 8'h50);
      wr(ix_ch, 8'hfe);
      wr(ix_cl, 8'hf8);
      wr(ix_tc, 8'h08);
      repeat (30) @(posedge pclk);
      rd(ix_ch, 8'hfe, "high held");
      apb(1'b0, ix_cl, 8'h00);
      check_rng(rv, 8'ha1, 8'he0, "low own reload");
      rd(ix_tc, 8'h48, "low flag");
      irq(8'h00, "low masked");
      wr(ix_tc, 8'h68);
      irq(8'h01, "low irq");
      wr(ix_tc, 8'h0c);
      repeat (20) @(posedge pclk);
      apb(1'b0, ix_ch, 8'h00);
      check_rng(rv, 8'h50, 8'h70, "high own reload");
      apb(1'b0, ix_tc, 8'h00);
      check_eq(rv & 8'hbf, 8'h8c, "high flag");
      irq(8'h01, "high irq");
      wr(ix_tc, 8'h00);
      $display("test split done");
   endtask : t_split
   task automatic t_clocks();
      wr(ix_ck, 8'h00);
      wr(ix_ch, 8'h00);
      wr(ix_cl, 8'h00);
      wr(ix_tc, 8'h04);
      repeat (120) @(posedge pclk);
      wr(ix_tc, 8'h00);
      apb(1'b0, ix_cl, 8'h00);
      check_rng(rv, 8'h0a, 8'h0b, "divide by twelve");
      wr(ix_cl, 8'h00);
      wr(ix_tc, 8'h05);
      slow(1'b1, 16);
      wr(ix_tc, 8'h00);
      rd(ix_cl, 8'h02, "external over eight");
      $display("test clocks done");
   endtask : t_clocks
   task automatic t_capture();
      wr(ix_ck, 8'h10);
      wr(ix_rl, 8'h00);
      wr(ix_tc, 8'h04);
      slow(1'b0, 8);
      rd(ix_rl, 8'h00, "no capture when off");
      rd(ix_tc, 8'h04, "no flag when off");
      for (int i = 0; i < 2; i++) begin
         wr(ix_ch, 8'h00);
         wr(ix_cl, 8'h00);
         wr(ix_tc, {6'b000101, i[0], 1'b0});
         slow(i[0], 8);
         rd(ix_rh, 8'h00, "capture high");
         apb(1'b0, ix_rl, 8'h00);
         check_rng(rv, 8'h30, 8'hc0, "capture low");
         apb(1'b0, ix_tc, 8'h00);
         check_eq(rv & 8'h80, 8'h80, "capture flag");
         wr(ix_tc, 8'h04);
      end
      $display("test capture done");
   endtask : t_capture
   initial begin
      {presetn, psel, penable, pwrite, ext_osc_clk, rtc_clk} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      {fails, checks, cycles} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_wide();
      t_split();
      t_clocks();
      t_capture();
      print_verdict();
   end
endmodule : rtcap_timer_tb
`default_nettype wire
